// [fbc_map.vh]
`ifndef FBC_MAP_VH
`define FBC_MAP_VH
// Register addresses
`define FBC_A_GAIN 7'h00
`define FBC_A_DRIVE 7'h01
`define FBC_A_LOAD 7'h02
`define FBC_A_RUN 7'h03
`define FBC_A_SRC 7'h05
`define FBC_A_LOWSW 7'h06
`define FBC_A_EN0 7'h07
`define FBC_A_EN1 7'h08
`define FBC_A_STR0 7'h09
`define FBC_A_STR1 7'h0A
`define FBC_A_ID 7'h11
// Reset values
`define FBC_R_GAIN 8'h00
`define FBC_R_DRIVE 8'h03
`define FBC_R_LOAD 8'h80
`define FBC_R_RUN 8'hFF
`define FBC_R_SRC 8'h00
`define FBC_R_LOWSW 8'h00
`define FBC_R_EN 8'h1F
`define FBC_R_STR 8'h00
// Fixed load code in hardware mode (8 pF)
`define FBC_HW_LOAD 8'h80
// Frame field lengths
`define FBC_ADDR_BITS 7
`define FBC_DATA_BITS 8
// Arbitrary identity value
`define FBC_ID_VALUE 8'h5A
`endif

// [fbc_regs.v]
`timescale 1ns/1ps
// Small register file; read data come out of a register
module fbc_regs #(
  parameter DEPTH = 16
) (
  input wire i_mclk,
  input wire i_nrst,
  input wire i_we,
  input wire [3:0] i_waddr,
  input wire [7:0] i_wdata,
  input wire [3:0] i_raddr,
  output reg [7:0] o_rdata,
  output wire [8*DEPTH-1:0] o_flat
);
`include "fbc_map.vh"
  reg [7:0] mem [0:DEPTH-1];
  genvar g;

  // -------------------------------
  // Storage with documented resets
  // -------------------------------
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : gen_cell
      always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
          case (g)
            0: mem[g] <= `FBC_R_GAIN;
            1: mem[g] <= `FBC_R_DRIVE;
            2: mem[g] <= `FBC_R_LOAD;
            3: mem[g] <= `FBC_R_RUN;
            7: mem[g] <= `FBC_R_EN;
            8: mem[g] <= `FBC_R_EN;
            default: mem[g] <= 8'h00;
          endcase
        end else if (i_we && i_waddr == g) begin
          mem[g] <= i_wdata;
        end
      end
      assign o_flat[8*g+7:8*g] = mem[g];
    end
  endgenerate

  // Registered read port
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule

// [fbc_control.v]
`timescale 1ns/1ps
// Overview of operation
// (R01) Strap low: pins configure source and enable
// (R02) Strap high: serial port configures everything
// (R03) Board keeps strap fixed while powered
// (R04) Pick pins map to four reference sources
// (R05) Low pick pin is serial clock
// (R06) High pick pin carries command, address, data
// (R07) Read data shifted out serial pin
// (R08) Outputs-on pin is active-low chip select
// (R09) Hardware mode: outputs-on gates all outputs
// (R10) Serial mode: one enable bit per output
// (R11) Per-output drive strength from software
// (R12) Serial load cap 0 to 21.75 pF
// (R13) Software gain eight steps, resistor six
// (R14) Hardware mode load fixed at 8 pF
// (R15) Frame: flag, seven address, eight data
// (R16) Clock level at select picks bit order
// (R17) Held select auto-increments address
// (R18) Half duplex: input ignored during reads
// (R19) Strap sampled once after reset
module fbc_control (
  input wire i_mclk,
  input wire i_nrst,
  input wire i_mode_strap,
  input wire i_source_pick_low,
  input wire i_source_pick_high,
  input wire i_outputs_on,
  output reg o_serial_mode,
  output reg [1:0] o_source_sel,
  output reg [9:0] o_fanout_enable,
  output reg [9:0] o_drive_strong,
  output reg [7:0] o_xtal_load,
  output reg [7:0] o_xtal_gain,
  output reg [7:0] o_xtal_drive,
  output reg o_xtal_normal_run,
  output reg o_output_drive_low,
  output reg o_serial_out_pin,
  output reg o_serial_out_oe
);
`include "fbc_map.vh"
  localparam ST_IDLE = 2'd0;
  localparam ST_ADDR = 2'd1;
  localparam ST_DATA = 2'd2;

  // -------------------------------
  // Pin synchronisers
  // -------------------------------
  reg [3:0] sync1;
  reg [3:0] sync2;
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end else begin
      sync1 <= {i_mode_strap, i_outputs_on, i_source_pick_high, i_source_pick_low};
      sync2 <= sync1;
    end
  end
  wire sck = sync2[0];
  wire sdi = sync2[1];
  wire csn = sync2[2];
  wire strap = sync2[3];

  // Strap caught once after release; a later change needs a reset
  // Capture waits until both synchroniser stages hold the real pin level
  reg [1:0] settle;
  reg strap_taken;
  reg mode;
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      settle <= 2'h0;
      strap_taken <= 1'b0;
      mode <= 1'b0;
    end else if (!strap_taken) begin
      if (settle == 2'h2) begin
        strap_taken <= 1'b1; // [R19] [R03]
        mode <= strap;
      end else begin
        settle <= settle + 2'h1;
      end
    end
  end

  // -------------------------------
  // Serial client
  // -------------------------------
  reg sck_d;
  reg csn_d;
  reg lsb_first;
  reg is_read;
  reg [1:0] state;
  reg [3:0] bitcnt;
  reg [6:0] addr;
  reg [7:0] shreg;
  reg [7:0] txreg;
  reg we;
  reg [7:0] wdata;
  reg [3:0] waddr;
  reg load_tx;
  wire [7:0] rdata;
  wire [127:0] flat;
  wire active = mode && strap_taken && !csn; // [R08]
  wire rise = active && sck && !sck_d; // [R05]
  wire fall = active && !sck && sck_d;
  wire start = mode && strap_taken && csn_d && !csn;
  // Incoming bit placed by order
  wire [7:0] next_shreg = lsb_first ? {sdi, shreg[7:1]} : {shreg[6:0], sdi};

  // Read data for addresses the store does not cover
  function [7:0] fbc_read_map;
    input [6:0] a;
    input [7:0] mem_q;
    begin
      if (a == `FBC_A_ID) begin
        fbc_read_map = `FBC_ID_VALUE;
      end else if (a < 7'h10) begin
        fbc_read_map = mem_q;
      end else begin
        fbc_read_map = 8'h00;
      end
    end
  endfunction

  fbc_regs #(.DEPTH(16)) u_regs (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_we(we),
    .i_waddr(waddr),
    .i_wdata(wdata),
    .i_raddr(addr[3:0]),
    .o_rdata(rdata),
    .o_flat(flat)
  );

  // Frame sequencer: flag, address, data bytes with auto-increment
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sck_d <= 1'b0;
      csn_d <= 1'b1;
      lsb_first <= 1'b0;
      is_read <= 1'b0;
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      addr <= 7'h00;
      shreg <= 8'h00;
      we <= 1'b0;
      wdata <= 8'h00;
      waddr <= 4'h0;
      load_tx <= 1'b0;
    end else begin
      sck_d <= sck;
      csn_d <= csn;
      we <= 1'b0;
      load_tx <= 1'b0;
      if (start) begin
        lsb_first <= sck; // [R16]
        state <= ST_IDLE;
        bitcnt <= 4'h0;
      end else if (!active) begin
        state <= ST_IDLE;
        bitcnt <= 4'h0;
      end else if (rise) begin
        shreg <= next_shreg;
        case (state)
          ST_IDLE: begin
            // Flag sits in its own slot ahead of the address
            is_read <= sdi; // [R15]
            state <= ST_ADDR;
            bitcnt <= 4'h0;
          end
          ST_ADDR: begin
            if (bitcnt == `FBC_ADDR_BITS - 1) begin
              addr <= lsb_first ? next_shreg[7:1] : next_shreg[6:0]; // [R15]
              state <= ST_DATA;
              bitcnt <= 4'h0;
              load_tx <= is_read;
            end else begin
              bitcnt <= bitcnt + 4'h1;
            end
          end
          default: begin
            if (bitcnt == `FBC_DATA_BITS - 1) begin
              bitcnt <= 4'h0;
              // Writes beyond the store are dropped; reads ignore input
              if (!is_read && addr < 7'h10) begin // [R18]
                we <= 1'b1;
                waddr <= addr[3:0];
                wdata <= next_shreg;
              end
              addr <= addr + 7'h01; // [R17]
              load_tx <= is_read;
            end else begin
              bitcnt <= bitcnt + 4'h1;
            end
          end
        endcase
      end
    end
  end

  // Output shifter: load lags one cycle for registered read data
  reg load_tx_d;
  wire [7:0] rd_byte = fbc_read_map(addr, rdata);
  // First fall of a byte keeps the freshly loaded bit; only later falls shift
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      load_tx_d <= 1'b0;
      txreg <= 8'h00;
      o_serial_out_pin <= 1'b0;
      o_serial_out_oe <= 1'b0;
    end else begin
      load_tx_d <= load_tx;
      o_serial_out_oe <= active && is_read && state == ST_DATA; // [R07]
      if (load_tx_d) begin
        txreg <= rd_byte;
        o_serial_out_pin <= lsb_first ? rd_byte[0] : rd_byte[7];
      end else if (fall && state == ST_DATA && is_read && bitcnt != 4'h0) begin
        txreg <= lsb_first ? {1'b0, txreg[7:1]} : {txreg[6:0], 1'b0};
        o_serial_out_pin <= lsb_first ? txreg[1] : txreg[6]; // [R07]
      end
    end
  end

  // -------------------------------
  // Configuration outputs
  // -------------------------------
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_serial_mode <= 1'b0;
      o_source_sel <= 2'b00;
      o_fanout_enable <= 10'h000;
      o_drive_strong <= 10'h000;
      o_xtal_load <= `FBC_HW_LOAD;
      o_xtal_gain <= `FBC_R_GAIN;
      o_xtal_drive <= `FBC_R_DRIVE;
      o_xtal_normal_run <= 1'b1;
      o_output_drive_low <= 1'b0;
    end else if (mode) begin
      o_serial_mode <= 1'b1; // [R02]
      o_source_sel <= flat[8*5+1:8*5];
      o_fanout_enable <= {flat[8*8+4:8*8], flat[8*7+4:8*7]}; // [R10]
      o_drive_strong <= {flat[8*10+4:8*10], flat[8*9+4:8*9]}; // [R11]
      o_xtal_load <= flat[8*2+7:8*2]; // [R12]
      o_xtal_gain <= flat[7:0]; // [R13]
      o_xtal_drive <= flat[8*1+7:8*1]; // [R13]
      o_xtal_normal_run <= flat[8*3];
      o_output_drive_low <= flat[8*6];
    end else begin
      o_serial_mode <= 1'b0; // [R01]
      o_source_sel <= {sdi, sck}; // [R04]
      o_fanout_enable <= {10{csn}}; // [R09]
      o_drive_strong <= {flat[8*10+4:8*10], flat[8*9+4:8*9]}; // [R11]
      o_xtal_load <= `FBC_HW_LOAD; // [R14]
      o_xtal_gain <= `FBC_R_GAIN;
      o_xtal_drive <= `FBC_R_DRIVE;
      o_xtal_normal_run <= 1'b1;
      o_output_drive_low <= 1'b0;
    end
  end
endmodule

// [fbc_checker.sv]
`timescale 1ns/1ps
// ----
// Pin behaviour checks
// ----
module fbc_checker (
  input wire i_mclk,
  input wire i_nrst,
  input wire i_mode_strap,
  input wire i_source_pick_low,
  input wire i_source_pick_high,
  input wire i_outputs_on,
  input wire o_serial_mode,
  input wire [1:0] o_source_sel,
  input wire [9:0] o_fanout_enable,
  input wire [7:0] o_xtal_load,
  input wire o_serial_out_oe
);
  reg [3:0] up;
  // Settle count; hides strap capture and pin latency after reset
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      up <= 4'h0;
    end else if (up != 4'hF) begin
      up <= up + 4'h1;
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  AST_MODE_TAKE: assert property (up == 4'h5 |-> o_serial_mode == $past(i_mode_strap, 2))
    else $error("mode differs from strap");
  AST_MODE_HOLD: assert property (up == 4'hF |-> $stable(o_serial_mode))
    else $error("mode moved");
  AST_HW_SRC: assert property (!o_serial_mode && up == 4'hF
    |-> o_source_sel == $past({i_source_pick_high, i_source_pick_low}, 3))
    else $error("source does not follow pins");
  AST_HW_EN: assert property (!o_serial_mode && up == 4'hF
    |-> o_fanout_enable == {10{$past(i_outputs_on, 3)}})
    else $error("enable does not follow pin");
  AST_HW_LOAD: assert property (!o_serial_mode |-> o_xtal_load == 8'h80)
    else $error("load not fixed");
  AST_HW_QUIET: assert property (!o_serial_mode |-> !o_serial_out_oe)
    else $error("serial out driven in pin mode");
  AST_OE_FRAME: assert property (i_outputs_on [*6] |-> !o_serial_out_oe)
    else $error("serial out driven without select");
  AST_EN_WRITE: assert property (o_serial_mode && up == 4'hF && $changed(o_fanout_enable)
    |-> !$past(i_outputs_on, 2))
    else $error("enable changed outside a frame");
  // Main scenarios reached
  AST_COV_READ: cover property (o_serial_out_oe);
  AST_COV_SER: cover property (o_serial_mode && up == 4'hF);
  AST_COV_BYP: cover property (!o_serial_mode && o_source_sel == 2'h3);
endmodule
bind fbc_control fbc_checker i_chk (
  .i_mclk(i_mclk), .i_nrst(i_nrst), .i_mode_strap(i_mode_strap),
  .i_source_pick_low(i_source_pick_low), .i_source_pick_high(i_source_pick_high),
  .i_outputs_on(i_outputs_on), .o_serial_mode(o_serial_mode),
  .o_source_sel(o_source_sel), .o_fanout_enable(o_fanout_enable),
  .o_xtal_load(o_xtal_load), .o_serial_out_oe(o_serial_out_oe));

// [fbc_host.sv]
`timescale 1ns/1ps
// ----
// Serial host on the shared pins
// ----
module fbc_host (
  input wire i_mclk,
  input wire i_sdo,
  output reg o_sck = 1'b1,
  output reg o_sdi = 1'b1,
  output reg o_csn = 1'b1
);
  // Half link period: 4 mclk, 80 ns full period
  task half;
    repeat (4) @(posedge i_mclk);
  endtask
  // One framed access; bytes packed low first in wd and q
  task xfer(input rd, input lsb, input [6:0] a, input [1:0] nb,
    input [23:0] wd, output [23:0] q);
    integer i;
    integer j;
    begin
      q = 24'h0;
      o_sck <= lsb; // Clock level at select picks order
      half;
      o_csn <= 1'b0; // Active-low select frames the access
      half; // Clock level must stand while select falls
      for (i = 0; i < 8 + 8 * nb; i = i + 1) begin
        j = (i - 8) / 8 * 8 + (lsb ? i % 8 : 7 - i % 8);
        o_sck <= 1'b0;
        // Flag, address, data; read data phase toggles sdi
        o_sdi <= i == 0 ? rd : i < 8 ? a[lsb ? i - 1 : 7 - i] : rd ? ~o_sdi : wd[j];
        half;
        o_sck <= 1'b1;
        half;
        if (rd && i >= 8) begin
          q[j] = i_sdo; // Sampled late in the high phase, bit is settled
        end
      end
      half;
      half;
      o_csn <= 1'b1;
      o_sdi <= 1'b1; // Released line sits at its pull-up
    end
  endtask
endmodule

// [fbc_control_bench.sv]
`timescale 1ns/1ps
`include "fbc_map.vh"
// ----
// Bench for the control pins
// ----
module fbc_control_bench;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg strap = 1'b0;
  reg ser = 1'b0;
  reg pl = 1'b0;
  reg ph = 1'b0;
  reg on = 1'b0;
  wire sck, sdi, csn, mode, sdo, oe;
  wire run, lowd;
  wire [1:0] src;
  wire [9:0] en, str;
  wire [7:0] load, gain, drv;
  reg [23:0] q;
  integer k;
  integer failures = 0;
  integer n_checks = 0;
  always #5 clk = ~clk;
  // Undriven output line reads inverted, so a missing enable spoils the data
  fbc_host i_h (.i_mclk(clk), .i_sdo(oe ? sdo : ~sdo), .o_sck(sck), .o_sdi(sdi), .o_csn(csn));
  fbc_control i_dut (.i_mclk(clk), .i_nrst(nrst), .i_mode_strap(strap),
    .i_source_pick_low(ser ? sck : pl), .i_source_pick_high(ser ? sdi : ph),
    .i_outputs_on(ser ? csn : on), .o_serial_mode(mode), .o_source_sel(src),
    .o_fanout_enable(en), .o_drive_strong(str), .o_xtal_load(load),
    .o_xtal_gain(gain), .o_xtal_drive(drv), .o_xtal_normal_run(run),
    .o_output_drive_low(lowd), .o_serial_out_pin(sdo), .o_serial_out_oe(oe));
  // Comparison and verdict
  task chk(input [23:0] got, input [23:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask
  // Reset with a strap value; strap only counts at reset
  task rst(input s);
    begin
      nrst <= 1'b0;
      strap <= s; // Strap moves here while reset holds
      ser <= s;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      repeat (8) @(posedge clk);
    end
  endtask
  // Pin mode, then serial mode after a second reset
  initial begin
    rst(1'b0);
    for (k = 0; k < 8; k = k + 1) begin
      {on, ph, pl} <= k[2:0];
      repeat (5) @(posedge clk);
      chk(src, k[1:0]);
      chk(en, {10{k[2]}});
      chk(load, 8'h80);
    end
    chk({run, lowd}, 2'h2);
    strap <= 1'b1;
    repeat (8) @(posedge clk);
    chk(mode, 1'b0);
    rst(1'b1);
    chk(mode, 1'b1);
    chk(run, 1'b1);
    i_h.xfer(1'b0, 1'b0, 7'h00, 2'h3, 24'hFF21A5, q);
    chk({load, drv, gain}, 24'hFF21A5);
    i_h.xfer(1'b0, 1'b1, 7'h07, 2'h2, 24'h000A15, q);
    i_h.xfer(1'b0, 1'b1, 7'h09, 2'h1, 24'h000003, q);
    chk(en, 10'h155);
    chk(str[4:0], 5'h03);
    i_h.xfer(1'b0, 1'b0, 7'h05, 2'h2, 24'h000102, q);
    chk(src, 2'h2);
    chk(lowd, 1'b1);
    i_h.xfer(1'b1, 1'b0, 7'h07, 2'h2, 24'h0, q);
    chk(q, 24'h000A15);
    chk(en, 10'h155);
    i_h.xfer(1'b1, 1'b1, 7'h11, 2'h1, 24'h0, q);
    chk(q, {16'h0000, `FBC_ID_VALUE});
    stop_test;
  end
  // Watchdog: all frames finish well inside this span
  initial begin
    #300000;
    failures = failures + 1;
    stop_test;
  end
endmodule
